// ==== hdl/ilr_pkg.sv ====
// Summary of operation
// - zero delay mode bit honoured only while feedback-source bit is 0
// - zero delay mode 1: receiver off, internal channel 0 path used
// - feedback-source 1 selects oscillator input feedback, 0 zero delay feedback
// - bit 2 sets zero delay receiver differential, else single-ended
// - bit 3 picks single-ended zero delay pin, only in single-ended mode
// - bits 1 and 0 pick reference pins only when differential enable is 0
// - misc bit 7 set: own secondary divider; clear: copy primary divider
// - bit 6 chooses midsupply force or tristated pump on reference failure
// - mode bit 4 clear: 00 nonrevert, 01 revert, 10 force primary, 11 force secondary
// - mode bit 4 set: selection pin low primary, high secondary
// - reset leaves selection mode 000, staying on secondary reference
// - each reference receiver differential when its enable is 1
package ilr_pkg;
    localparam logic [9:0] FB_RX_CTRL_OFS = 10'h01B;
    localparam logic [9:0] MISC_CTRL_OFS  = 10'h01C;
    localparam logic [7:0] FB_RX_RST      = 8'h00;
    localparam logic [7:0] MISC_RST       = 8'h00;
    localparam logic [7:0] FB_RX_WMASK    = 8'h3F;
    localparam logic [7:0] MISC_WMASK     = 8'hDC;
    localparam int ZD_MODE_BIT  = 5;
    localparam int FB_SRC_BIT   = 4;
    localparam int ZD_PIN_BIT   = 3;
    localparam int ZD_DIFF_BIT  = 2;
    localparam int SEC_PIN_BIT  = 1;
    localparam int PRI_PIN_BIT  = 0;
    localparam int DIV_IND_BIT  = 7;
    localparam int FAIL_MID_BIT = 6;
    localparam int SEL_HI_BIT   = 4;
    localparam int SEL_LO_BIT   = 2;
    localparam logic [1:0] SEL_NONREV  = 2'h0;
    localparam logic [1:0] SEL_REVERT  = 2'h1;
    localparam logic [1:0] SEL_FORCE_P = 2'h2;
    localparam logic [1:0] SEL_FORCE_S = 2'h3;
    typedef enum logic [1:0] {ILR_FB_OSC, ILR_FB_ZD_EXT, ILR_FB_ZD_INT} ilr_fb_t;
endpackage : ilr_pkg

// ==== hdl/ilr_ref_sel.sv ====
`timescale 1ns/100ps
`default_nettype none
module ilr_ref_sel
    import ilr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [2:0] sel_mode,
    input  wire logic       ref_sel_pin,
    input  wire logic       primary_lost,
    input  wire logic       secondary_lost,
    output logic            use_secondary
);
    logic auto_sec_r;
    logic auto_sec_nxt;

    always_comb begin
        auto_sec_nxt = auto_sec_r;
        if (!auto_sec_r && primary_lost && !secondary_lost)
            auto_sec_nxt = 1'b1;
        else if (auto_sec_r && secondary_lost && !primary_lost)
            auto_sec_nxt = 1'b0;
        else if (auto_sec_r && sel_mode[1:0] == SEL_REVERT && !primary_lost)
            auto_sec_nxt = 1'b0;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            auto_sec_r <= 1'b1;
        else
            auto_sec_r <= auto_sec_nxt;
    end

    always_comb begin
        if (sel_mode[2])
            use_secondary = ref_sel_pin;
        else begin
            case (sel_mode[1:0])
                SEL_FORCE_P: use_secondary = 1'b0;
                SEL_FORCE_S: use_secondary = 1'b1;
                default:     use_secondary = auto_sec_r;
            endcase
        end
    end

    a_pin_mode: assert property (@(posedge core_clk) disable iff (!resetn)
        sel_mode[2] |-> use_secondary == ref_sel_pin) else $error("pin mode mismatch");
    a_force_pri: assert property (@(posedge core_clk) disable iff (!resetn)
        sel_mode == 3'h2 |-> !use_secondary) else $error("force primary broken");
    a_force_sec: assert property (@(posedge core_clk) disable iff (!resetn)
        sel_mode == 3'h3 |-> use_secondary) else $error("force secondary broken");
    a_revert_back: assert property (@(posedge core_clk) disable iff (!resetn)
        (sel_mode == 3'h1 && auto_sec_r && !primary_lost) |=> !auto_sec_r) else $error("no revert");
    a_nonrev_stay: assert property (@(posedge core_clk) disable iff (!resetn)
        (sel_mode == 3'h0 && auto_sec_r && !secondary_lost) |=> auto_sec_r) else $error("nonrevert left");
endmodule : ilr_ref_sel
`default_nettype wire

// ==== hdl/ilr_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ilr_top
    import ilr_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [9:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic       ref_sel_pin,
    input  wire logic       primary_lost,
    input  wire logic       secondary_lost,
    input  wire logic       primary_diff_en,
    input  wire logic       secondary_diff_en,
    output logic            zd_rx_enable,
    output logic            zd_rx_diff,
    output logic            zd_rx_pin_sel,
    output logic            zd_internal_path,
    output logic            fb_from_oscillator,
    output logic            primary_rx_diff,
    output logic            primary_pin_sel,
    output logic            secondary_rx_diff,
    output logic            secondary_pin_sel,
    output logic            secondary_div_independent,
    output logic            ref_fail,
    output logic            force_midsupply,
    output logic            pump_tristate,
    output logic            use_secondary
);
    import ilr_pkg::*;

    logic [7:0] fb_ctrl_r;
    logic [7:0] misc_r;
    logic       use_sec_c;
    logic       ref_fail_c;
    ilr_fb_t    fb_path_c;
    logic       zd_int_c;
    logic       zd_en_c;

    ////////////////////////////////////////////////////////////////
    // helpers shared by the write, assertion and output paths
    function automatic logic addr_hit(input logic [9:0] addr, input logic [9:0] ofs);
        return addr == ofs;
    endfunction : addr_hit

    // a single-ended pin choice only counts while the receiver is not differential
    function automatic logic se_pin(input logic diff, input logic pick);
        return !diff && pick;
    endfunction : se_pin

    function automatic ilr_fb_t fb_path(input logic [7:0] ctrl);
        ilr_fb_t path;
        if (ctrl[FB_SRC_BIT])
            path = ILR_FB_OSC;
        else if (ctrl[ZD_MODE_BIT])
            path = ILR_FB_ZD_INT;
        else
            path = ILR_FB_ZD_EXT;
        return path;
    endfunction : fb_path

    ////////////////////////////////////////////////////////////////
    // registers; reserved bits stay zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            fb_ctrl_r <= FB_RX_RST;
        else if (reg_wr && addr_hit(reg_addr, FB_RX_CTRL_OFS))
            fb_ctrl_r <= reg_wdata & FB_RX_WMASK;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            misc_r <= MISC_RST;
        else if (reg_wr && addr_hit(reg_addr, MISC_CTRL_OFS))
            misc_r <= reg_wdata & MISC_WMASK;
    end

    always_comb begin
        case (reg_addr)
            FB_RX_CTRL_OFS: reg_rdata = fb_ctrl_r;
            MISC_CTRL_OFS:  reg_rdata = misc_r;
            default:        reg_rdata = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    ilr_ref_sel u_sel (
        .core_clk       (core_clk),
        .resetn         (resetn),
        .sel_mode       (misc_r[SEL_HI_BIT:SEL_LO_BIT]),
        .ref_sel_pin    (ref_sel_pin),
        .primary_lost   (primary_lost),
        .secondary_lost (secondary_lost),
        .use_secondary  (use_sec_c)
    );

    assign ref_fail_c = use_sec_c ? secondary_lost : primary_lost;

    // feedback path decode
    // decoded once so the internal path and the receiver are never both on
    always_comb begin
        fb_path_c = fb_path(fb_ctrl_r);
        case (fb_path_c)
            ILR_FB_ZD_INT: begin
                zd_int_c = 1'b1;
                zd_en_c  = 1'b0;
            end
            ILR_FB_ZD_EXT: begin
                zd_int_c = 1'b0;
                zd_en_c  = 1'b1;
            end
            default: begin
                zd_int_c = 1'b0;
                zd_en_c  = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // outputs registered so receivers see glitch-free controls
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            zd_rx_enable       <= 1'b0;
            zd_internal_path   <= 1'b0;
            fb_from_oscillator <= 1'b0;
            zd_rx_diff         <= 1'b0;
            zd_rx_pin_sel      <= 1'b0;
        end else begin
            fb_from_oscillator <= fb_ctrl_r[FB_SRC_BIT];
            // zero delay mode gated by source
            zd_internal_path   <= zd_int_c;
            zd_rx_enable       <= zd_en_c;
            zd_rx_diff         <= fb_ctrl_r[ZD_DIFF_BIT];
            zd_rx_pin_sel      <= se_pin(fb_ctrl_r[ZD_DIFF_BIT], fb_ctrl_r[ZD_PIN_BIT]);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            primary_rx_diff   <= 1'b0;
            primary_pin_sel   <= 1'b0;
            secondary_rx_diff <= 1'b0;
            secondary_pin_sel <= 1'b0;
        end else begin
            primary_rx_diff   <= primary_diff_en;
            secondary_rx_diff <= secondary_diff_en;
            primary_pin_sel   <= se_pin(primary_diff_en, fb_ctrl_r[PRI_PIN_BIT]);
            secondary_pin_sel <= se_pin(secondary_diff_en, fb_ctrl_r[SEC_PIN_BIT]);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            secondary_div_independent <= 1'b0;
            ref_fail                  <= 1'b0;
            force_midsupply           <= 1'b0;
            pump_tristate             <= 1'b0;
            use_secondary             <= 1'b1;
        end else begin
            // divider sharing; shared use relies on equal frequencies
            secondary_div_independent <= misc_r[DIV_IND_BIT];
            ref_fail                  <= ref_fail_c;
            force_midsupply           <= ref_fail_c && misc_r[FAIL_MID_BIT];
            pump_tristate             <= ref_fail_c && !misc_r[FAIL_MID_BIT];
            use_secondary             <= use_sec_c;
        end
    end

    ////////////////////////////////////////////////////////////////
    a_zd_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
        fb_ctrl_r[FB_SRC_BIT] |=> !zd_rx_enable && !zd_internal_path) else $error("zd mode not ignored");
    a_zd_internal: assert property (@(posedge core_clk) disable iff (!resetn)
        (fb_ctrl_r[5:4] == 2'b10) |=> zd_internal_path && !zd_rx_enable) else $error("internal zd wrong");
    a_fb_source: assert property (@(posedge core_clk) disable iff (!resetn)
        1'b1 |=> fb_from_oscillator == $past(fb_ctrl_r[FB_SRC_BIT])) else $error("feedback source wrong");
    a_zd_pin_se: assert property (@(posedge core_clk) disable iff (!resetn)
        zd_rx_pin_sel |-> !zd_rx_diff) else $error("zd pin while differential");
    a_ref_pin_se: assert property (@(posedge core_clk) disable iff (!resetn)
        (primary_pin_sel |-> !primary_rx_diff) and (secondary_pin_sel |-> !secondary_rx_diff))
        else $error("ref pin while differential");
    a_fail_action: assert property (@(posedge core_clk) disable iff (!resetn)
        ref_fail |-> (force_midsupply != pump_tristate)) else $error("failure action wrong");
    a_div_share: assert property (@(posedge core_clk) disable iff (!resetn)
        (reg_wr && addr_hit(reg_addr, MISC_CTRL_OFS)) |=> ##1 secondary_div_independent == $past(reg_wdata[7], 2))
        else $error("divider mode wrong");

    ////////////////////////////////////////////////////////////////
    // field to output checks: zero delay, receivers, divider, failure action, selection pin
    a_zd_external: assert property (@(posedge core_clk) disable iff (!resetn)
        (!fb_ctrl_r[FB_SRC_BIT] && !fb_ctrl_r[ZD_MODE_BIT]) |=> zd_rx_enable && !zd_internal_path) else $error("zd receiver off");
    a_zd_feedback: assert property (@(posedge core_clk) disable iff (!resetn)
        !fb_ctrl_r[FB_SRC_BIT] |=> !fb_from_oscillator && (zd_rx_enable || zd_internal_path)) else $error("no zd feedback");
    a_zd_diff: assert property (@(posedge core_clk) disable iff (!resetn)
        1'b1 |=> zd_rx_diff == $past(fb_ctrl_r[ZD_DIFF_BIT])) else $error("zd receiver mode wrong");
    a_zd_pin_pick: assert property (@(posedge core_clk) disable iff (!resetn)
        !fb_ctrl_r[ZD_DIFF_BIT] |=> zd_rx_pin_sel == $past(fb_ctrl_r[ZD_PIN_BIT])) else $error("zd pin pick wrong");
    a_ref_diff: assert property (@(posedge core_clk) disable iff (!resetn)
        1'b1 |=> (primary_rx_diff == $past(primary_diff_en)) && (secondary_rx_diff == $past(secondary_diff_en))) else $error("ref receiver mode wrong");
    a_div_follow: assert property (@(posedge core_clk) disable iff (!resetn)
        1'b1 |=> secondary_div_independent == $past(misc_r[DIV_IND_BIT])) else $error("divider sharing wrong");
    a_mid_force: assert property (@(posedge core_clk) disable iff (!resetn)
        (ref_fail_c && misc_r[FAIL_MID_BIT]) |=> force_midsupply && !pump_tristate) else $error("midsupply not forced");
    a_pump_tri: assert property (@(posedge core_clk) disable iff (!resetn)
        (ref_fail_c && !misc_r[FAIL_MID_BIT]) |=> pump_tristate && !force_midsupply) else $error("pump not tristated");
    a_no_fail_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
        !ref_fail |-> !force_midsupply && !pump_tristate) else $error("failure action without failure");
    a_fail_pick: assert property (@(posedge core_clk) disable iff (!resetn)
        1'b1 |=> ref_fail == $past(use_sec_c ? secondary_lost : primary_lost)) else $error("failure flag wrong");
    a_pin_follow: assert property (@(posedge core_clk) disable iff (!resetn)
        misc_r[SEL_HI_BIT] |=> use_secondary == $past(ref_sel_pin)) else $error("pin mode output wrong");
endmodule : ilr_top
`default_nettype wire

// ==== verif/ilr_ref_env.sv ====
`timescale 1ns/100ps
`default_nettype none
module ilr_ref_env (
    input  wire logic pin_cmd,
    input  wire logic pri_bad,
    input  wire logic sec_bad,
    output logic      ref_sel_pin,
    output logic      primary_lost,
    output logic      secondary_lost
);
    // equal reference rates
    // one shared source rate, so a shared divider never unlocks the loop
    assign ref_sel_pin    = pin_cmd;
    assign primary_lost   = pri_bad;
    assign secondary_lost = sec_bad;
endmodule : ilr_ref_env
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ilr_pkg::*;
    logic       core_clk, resetn, reg_wr, pin_cmd, pri_bad, sec_bad, pd, sd;
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic       ref_sel_pin, primary_lost, secondary_lost, zd_rx_enable, zd_rx_diff, zd_rx_pin_sel;
    logic       zd_internal_path, fb_from_oscillator, primary_rx_diff, primary_pin_sel, secondary_rx_diff;
    logic       secondary_pin_sel, secondary_div_independent, ref_fail, force_midsupply, pump_tristate;
    logic       use_secondary;
    int         bad_count, checks;
    logic [7:0] last_fb;
    ilr_ref_env ilr_ref_env_i (.pin_cmd(pin_cmd), .pri_bad(pri_bad), .sec_bad(sec_bad),
        .ref_sel_pin(ref_sel_pin), .primary_lost(primary_lost), .secondary_lost(secondary_lost));
    ilr_top ilr_top_i (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_sel_pin(ref_sel_pin),
        .primary_lost(primary_lost), .secondary_lost(secondary_lost), .primary_diff_en(pd),
        .secondary_diff_en(sd), .zd_rx_enable(zd_rx_enable), .zd_rx_diff(zd_rx_diff),
        .zd_rx_pin_sel(zd_rx_pin_sel), .zd_internal_path(zd_internal_path),
        .fb_from_oscillator(fb_from_oscillator), .primary_rx_diff(primary_rx_diff),
        .primary_pin_sel(primary_pin_sel), .secondary_rx_diff(secondary_rx_diff),
        .secondary_pin_sel(secondary_pin_sel), .secondary_div_independent(secondary_div_independent),
        .ref_fail(ref_fail), .force_midsupply(force_midsupply), .pump_tristate(pump_tristate),
        .use_secondary(use_secondary));
    wire logic [8:0] fb_seen = {zd_rx_enable, zd_internal_path, fb_from_oscillator, zd_rx_diff,
        zd_rx_pin_sel, primary_rx_diff, primary_pin_sel, secondary_rx_diff, secondary_pin_sel};
    wire logic [8:0] misc_seen = {4'h0, secondary_div_independent, use_secondary, ref_fail,
        force_midsupply, pump_tristate};
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] fb_exp(input logic [7:0] d, input logic a, input logic b);
        return {!d[4] & !d[5], !d[4] & d[5], d[4], d[2], d[3] & !d[2], a, d[0] & !a, b, d[1] & !b};
    endfunction : fb_exp
    // forced codes 10/11 pick by bit 2; pin mode follows the pin
    function automatic logic [8:0] misc_exp(input logic [7:0] d, input logic p, a, b);
        logic s;
        logic f;
        s = d[4] ? p : d[2];
        f = s ? b : a;
        return {4'h0, d[7], s, f, f & d[6], f & !d[6]};
    endfunction : misc_exp
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : wr
    task automatic setin(input logic p, input logic a, input logic b);
        @(posedge core_clk);
        pin_cmd <= p;
        pri_bad <= a;
        sec_bad <= b;
        repeat (3) @(posedge core_clk);
        #1;
    endtask : setin
    task automatic end_sim;
        $display("errors %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        end_sim();
    end
    initial begin
        {resetn, reg_wr, pin_cmd, pri_bad, sec_bad, pd, sd, reg_addr, reg_wdata} = '0;
        void'($urandom(27911));
        repeat (3) @(posedge core_clk);
        #1;
        chk("reset_out", 9'h008, misc_seen); // secondary in reset
        chk("reset_fb", 9'h000, fb_seen);
        @(posedge core_clk);
        resetn <= 1'b1;
        reg_addr <= MISC_CTRL_OFS;
        setin(0, 0, 0);
        chk("fb_idle", fb_exp(8'h00, 0, 0), fb_seen);
        chk("rd_misc", {1'b0, MISC_RST}, {1'b0, reg_rdata}); // read zero
        setin(0, 0, 1);
        chk("nonrev_sw", 9'h000, {7'h0, use_secondary, ref_fail}); // leaves lost secondary
        setin(0, 0, 0);
        chk("nonrev_stay", 9'h000, {7'h0, use_secondary, ref_fail}); // no return
        wr(MISC_CTRL_OFS, 8'h04);
        setin(0, 1, 0);
        chk("rev_sw", 9'h002, {7'h0, use_secondary, ref_fail}); // to secondary
        setin(0, 0, 0);
        chk("rev_back", 9'h000, {7'h0, use_secondary, ref_fail}); // back to primary
        for (int i = 0; i < 24; i++) begin
            v  = 8'($urandom);
            pd <= 1'($urandom);
            sd <= 1'($urandom);
            wr(FB_RX_CTRL_OFS, v);
            chk("fb_out", fb_exp(v, pd, sd), fb_seen);
            chk("fb_rd", {1'b0, v & FB_RX_WMASK}, {1'b0, reg_rdata});
        end
        // auto codes skipped: their state depends on history, covered above
        for (int i = 0; i < 24; i++) begin
            v = 8'($urandom);
            if (v[4:3] == 2'b00) v[3] = 1'b1;
            setin(1'($urandom), 1'($urandom), 1'($urandom));
            wr(MISC_CTRL_OFS, v);
            chk("misc_out", misc_exp(v, pin_cmd, pri_bad, sec_bad), misc_seen);
            chk("misc_rd", {1'b0, v & MISC_WMASK}, {1'b0, reg_rdata});
        end
        wr(10'h01D, 8'hFF);
        chk("unmapped_rd", 9'h000, {1'b0, reg_rdata});
        wr(10'h11B, 8'hFF);
        @(posedge core_clk);
        reg_addr <= FB_RX_CTRL_OFS;
        #1;
        chk("alias_wr", {1'b0, v & 8'h00} | fb_rd_keep(), {1'b0, reg_rdata});
        end_sim();
    end
    always @(posedge core_clk) if (reg_wr && reg_addr == FB_RX_CTRL_OFS) last_fb <= reg_wdata & FB_RX_WMASK;
    function automatic logic [8:0] fb_rd_keep();
        return {1'b0, last_fb};
    endfunction : fb_rd_keep
endmodule : testbench
`default_nettype wire
